// *** src/pwic_cfg.svh ***
// constants for the port wakeup and interrupt control block
`ifndef PWIC_CFG_SVH
`define PWIC_CFG_SVH
`define PWIC_SEL_DIR 8'h1F
`define PWIC_SEL_EDGE 8'h1A
`define PWIC_SEL_EN 8'h1B
`define PWIC_SEL_PEND 8'h19
`define PWIC_SEL_CMP 8'h18
`define PWIC_EN_RST 8'hFF
`define PWIC_EDGE_RST 8'hFF
`define PWIC_DIR_RST 8'hFF
`define PWIC_VECTOR 12'h000
`define PWIC_PC_MAX 12'hFFF
`define PWIC_PA_LSB 5
`define PWIC_RTC_ROLL 8'hFF
`endif

// *** src/pwic_pkg.sv ***
// types for the port wakeup and interrupt control block
package pwic_pkg;
  typedef enum logic [1:0] {PWIC_RUN, PWIC_ISR} pwic_state_e;
  typedef struct packed {
    logic [11:0] pc;
    logic [7:0] file_select_register;
    logic [7:0] status;
    logic [7:0] w;
  } pwic_ctx_s;
  typedef struct packed {
    logic [2:0] t1;
    logic [2:0] t2;
  } pwic_timer_irq_s;
endpackage : pwic_pkg

// *** src/pwic_top.sv ***
// port b wakeup, interrupt sequencing and context save logic
//
// Contract
// - pending register reset value undefined, software clears; the code resets it to 00h
// - selector 19h swaps working with pending
// - other targets except comparator (18h) copy without returning old value
// - selector picks direction, edge or enable
// - enable bits active low, clear permits pin
// - edge bit set falling, clear rising
// - reset loads enable and edge with ones
// - eight port b edge interrupts while awake
// - counter rollover raises internal interrupt
// - timers one and two: three sources each
// - equal priority, disabled until return
// - program counter pushed on single-level stack
// - file select, status, working copied to shadows
// - page bits cleared after status shadow copy
// - entry loads program counter with zero
// - return restores counter and shadowed registers
// - add-literal return adds literal to counter
// - either return re-enables interrupts
// - event during routine pends, taken after return
// - pending one means edge seen since clear
// - wakeup from power down branches to top
`timescale 1ns/1ps
`include "pwic_cfg.svh"
module pwic_top
  import pwic_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_port_b,
  input wire logic i_port_wr,
  input wire logic [7:0] i_mode_sel,
  input wire logic [7:0] i_w_data,
  input wire logic [7:0] i_cmp_result,
  input wire logic i_sleeping,
  input wire logic i_rtc_inc,
  input wire logic [7:0] i_rtc_value,
  input wire logic i_rtc_irq_en,
  input wire logic i_rtc_flag_clr,
  input wire pwic_timer_irq_s i_timer_irq,
  input wire logic i_ack_slot,
  input wire pwic_ctx_s i_ctx,
  input wire logic i_ret,
  input wire logic i_ret_add,
  input wire logic [7:0] i_ret_literal,
  output logic [7:0] o_swap_data,
  output logic o_swap_valid,
  output logic [7:0] o_port_b_dir,
  output logic [7:0] o_port_b_wake_enable,
  output logic [7:0] o_port_b_edge_select,
  output logic [7:0] o_port_b_wake_pending,
  output logic o_rtc_pending,
  output logic o_irq_req,
  output logic o_irq_enter,
  output logic o_wakeup,
  output pwic_ctx_s o_ctx_load,
  output logic o_ctx_load_valid,
  output logic o_rtc_add_valid,
  output logic [7:0] o_rtc_add,
  output logic o_global_en
);

  // ----------------------------------------------------------------
  // pin synchroniser and edge detect
  // ----------------------------------------------------------------
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;
  logic [7:0] pin_prev;
  logic [7:0] pend;
  logic [7:0] enb;
  logic [7:0] edge_sel;
  logic [7:0] dir;
  pwic_state_e state;
  pwic_ctx_s shadow;
  logic global_en;
  logic rtc_pend;
  logic ack_state;

  always_ff @(posedge i_ref_clk) begin
    pin_meta <= i_port_b;
    pin_sync <= pin_meta;
    pin_prev <= pin_sync;
  end

  wire [7:0] rise = pin_sync & ~pin_prev;
  wire [7:0] fall = ~pin_sync & pin_prev;
  wire [7:0] edge_hit = (edge_sel & fall) | (~edge_sel & rise);

  // ----------------------------------------------------------------
  // control target decode
  // ----------------------------------------------------------------
  wire wr_dir = i_port_wr && (i_mode_sel == `PWIC_SEL_DIR);
  wire wr_edge = i_port_wr && (i_mode_sel == `PWIC_SEL_EDGE);
  wire wr_en = i_port_wr && (i_mode_sel == `PWIC_SEL_EN);
  wire wr_pend = i_port_wr && (i_mode_sel == `PWIC_SEL_PEND);
  wire wr_cmp = i_port_wr && (i_mode_sel == `PWIC_SEL_CMP);
  wire [7:0] next_pend = wr_pend ? (i_w_data | edge_hit) : (pend | edge_hit);

  // ----------------------------------------------------------------
  // port b registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      enb <= `PWIC_EN_RST;
      edge_sel <= `PWIC_EDGE_RST;
      dir <= `PWIC_DIR_RST;
      pend <= 8'h00;
    end else begin
      if (wr_en) enb <= i_w_data;
      if (wr_edge) edge_sel <= i_w_data;
      if (wr_dir) dir <= i_w_data;
      pend <= next_pend;
    end
  end

  // swap returns old value for pending and comparator only
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_swap_data <= 8'h00;
      o_swap_valid <= 1'b0;
    end else begin
      o_swap_valid <= wr_pend | wr_cmp;
      if (wr_pend) o_swap_data <= pend;
      else if (wr_cmp) o_swap_data <= i_cmp_result;
    end
  end

  // ----------------------------------------------------------------
  // interrupt sources
  // ----------------------------------------------------------------
  wire rtc_roll = i_rtc_inc && (i_rtc_value == `PWIC_RTC_ROLL);
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) rtc_pend <= 1'b0;
    else rtc_pend <= rtc_roll | (rtc_pend & ~i_rtc_flag_clr);
  end

  wire port_src = |(pend & ~enb);
  wire timer_src = |i_timer_irq.t1 | |i_timer_irq.t2;
  wire any_src = (port_src & ~i_sleeping) | (rtc_pend & i_rtc_irq_en) | timer_src;
  wire irq_req = any_src & global_en;
  wire enter = irq_req & i_ack_slot & (state == PWIC_RUN);
  wire ret_any = (i_ret | i_ret_add) & (state == PWIC_ISR);

  // ----------------------------------------------------------------
  // entry and return sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      state <= PWIC_RUN;
      global_en <= 1'b1;
      shadow <= '0;
    end else begin
      case (state)
        PWIC_RUN: begin
          if (enter) begin
            state <= PWIC_ISR;
            global_en <= 1'b0;
            shadow <= i_ctx;
          end
        end
        PWIC_ISR: begin
          if (ret_any) begin
            state <= PWIC_RUN;
            global_en <= 1'b1;
          end
        end
        default: state <= PWIC_RUN;
      endcase
    end
  end

  pwic_ctx_s entry_ctx;
  always_comb begin
    entry_ctx = i_ctx;
    entry_ctx.pc = `PWIC_VECTOR;
    entry_ctx.status[`PWIC_PA_LSB +: 3] = 3'b000;
  end

  wire wake = i_sleeping && port_src;

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      o_ctx_load <= '0;
      o_ctx_load_valid <= 1'b0;
      o_irq_enter <= 1'b0;
      o_rtc_add_valid <= 1'b0;
      o_rtc_add <= 8'h00;
      o_wakeup <= 1'b0;
    end else begin
      o_irq_enter <= enter;
      o_ctx_load_valid <= enter | ret_any | wake;
      o_wakeup <= wake;
      o_rtc_add_valid <= ret_any & i_ret_add;
      o_rtc_add <= i_ret_literal;
      if (wake) begin
        o_ctx_load <= i_ctx;
        o_ctx_load.pc <= `PWIC_PC_MAX;
      end else if (enter) o_ctx_load <= entry_ctx;
      else if (ret_any) o_ctx_load <= shadow;
    end
  end

  assign o_port_b_dir = dir;
  assign o_port_b_wake_enable = enb;
  assign o_port_b_edge_select = edge_sel;
  assign o_port_b_wake_pending = pend;
  assign o_rtc_pending = rtc_pend;
  assign o_irq_req = irq_req;
  assign o_global_en = global_en;
  assign ack_state = (state == PWIC_ISR);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_reset_ones;
    @(posedge i_ref_clk) !i_resetn |=> (enb == 8'hFF) && (edge_sel == 8'hFF);
  endproperty
  a_reset_ones: assert property (p_reset_ones) else $error("reset values wrong");

  property p_swap;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      wr_pend |=> o_swap_valid && o_swap_data == $past(pend);
  endproperty
  a_swap: assert property (p_swap) else $error("swap returned wrong value");

  property p_no_swap;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (wr_en | wr_edge | wr_dir) |=> !o_swap_valid;
  endproperty
  a_no_swap: assert property (p_no_swap) else $error("copy target swapped");

  property p_edge_sel;
    @(posedge i_ref_clk) disable iff (!i_resetn) wr_edge |=> edge_sel == $past(i_w_data);
  endproperty
  a_edge_sel: assert property (p_edge_sel) else $error("edge write lost");

  property p_fall;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (edge_sel[0] && fall[0] && !wr_pend) |=> pend[0];
  endproperty
  a_fall: assert property (p_fall) else $error("falling edge not latched");

  property p_req;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (global_en && !i_sleeping && |(pend & ~enb)) |-> o_irq_req;
  endproperty
  a_req: assert property (p_req) else $error("request missing");

  property p_masked;
    @(posedge i_ref_clk) disable iff (!i_resetn) ack_state |-> !o_irq_req;
  endproperty
  a_masked: assert property (p_masked) else $error("request during routine");

  sequence s_enter;
    enter ##1 o_ctx_load_valid;
  endsequence
  property p_vector;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (enter && !wake) ##1 1'b1 |-> o_ctx_load.pc == 12'h000 && o_ctx_load.status[7:5] == 3'b000;
  endproperty
  a_vector: assert property (p_vector) else $error("vector or page bits wrong");

  property p_restore;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      s_enter ##[1:50] (ret_any && !wake) |=> o_ctx_load == $past(shadow) && global_en;
  endproperty
  a_restore: assert property (p_restore) else $error("restore wrong");

  property p_wake;
    @(posedge i_ref_clk) disable iff (!i_resetn) wake |=> o_wakeup && o_ctx_load.pc == 12'hFFF;
  endproperty
  a_wake: assert property (p_wake) else $error("wakeup branch wrong");

  sequence s_take;
    irq_req && i_ack_slot && (state == PWIC_RUN);
  endsequence
  sequence s_entered;
    o_irq_enter && o_ctx_load_valid && ack_state && !global_en;
  endsequence
  property p_enter;
    @(posedge i_ref_clk) disable iff (!i_resetn) s_take |=> s_entered;
  endproperty
  a_enter: assert property (p_enter) else $error("entry not taken");

  property p_shadow;
    @(posedge i_ref_clk) disable iff (!i_resetn) enter |=> shadow == $past(i_ctx);
  endproperty
  a_shadow: assert property (p_shadow) else $error("context not saved");

  property p_return;
    @(posedge i_ref_clk) disable iff (!i_resetn) ret_any |=> global_en && !ack_state;
  endproperty
  a_return: assert property (p_return) else $error("return left masked");

  property p_add;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      (ret_any && i_ret_add) |=> o_rtc_add_valid && o_rtc_add == $past(i_ret_literal);
  endproperty
  a_add: assert property (p_add) else $error("counter add wrong");

  property p_roll;
    @(posedge i_ref_clk) disable iff (!i_resetn) rtc_roll |=> o_rtc_pending;
  endproperty
  a_roll: assert property (p_roll) else $error("rollover not latched");

  property p_cmp_swap;
    @(posedge i_ref_clk) disable iff (!i_resetn)
      wr_cmp |=> o_swap_valid && o_swap_data == $past(i_cmp_result);
  endproperty
  a_cmp_swap: assert property (p_cmp_swap) else $error("comparator swap wrong");

endmodule : pwic_top

// *** tb/pwic_pin_model.sv ***
// pin driver standing in for external port b edge sources
`timescale 1ns/1ps
module pwic_pin_model (
  input wire logic i_clk,
  input wire logic [7:0] i_target,
  input wire logic [3:0] i_lag,
  output logic [7:0] o_pins
);
  logic [3:0] cnt;
  initial begin
    o_pins = 8'h00;
    cnt = 4'h0;
  end
  // pins follow the target after a chosen lag, prompt or slow
  always @(posedge i_clk) begin
    if (i_target === o_pins) cnt <= 4'h0;
    else if (cnt >= i_lag) o_pins <= i_target;
    else cnt <= cnt + 4'h1;
  end
endmodule : pwic_pin_model

// *** tb/pwic_top_tb.sv ***
// self-checking bench for the port wakeup and interrupt control block
`timescale 1ns/1ps
module pwic_top_tb;
  import pwic_pkg::*;
  logic i_ref_clk, i_resetn, i_port_wr, i_sleeping, i_rtc_inc, i_rtc_irq_en, i_rtc_flag_clr;
  logic i_ack_slot, i_ret, i_ret_add, o_swap_valid, o_rtc_pending, o_irq_req, o_irq_enter;
  logic o_wakeup, o_ctx_load_valid, o_rtc_add_valid, o_global_en;
  logic [7:0] i_port_b, i_mode_sel, i_w_data, i_cmp_result, i_rtc_value, i_ret_literal, tgt, d;
  logic [7:0] o_swap_data, o_port_b_dir, o_port_b_wake_enable, o_port_b_edge_select;
  logic [7:0] o_port_b_wake_pending, o_rtc_add;
  logic [3:0] lag;
  pwic_timer_irq_s i_timer_irq;
  pwic_ctx_s i_ctx, o_ctx_load, saved;
  logic [71:0] q_swap[$], q_ctx[$], q_add[$], q_enter[$];
  int errors, checks;
  pwic_top dut (.i_ref_clk, .i_resetn, .i_port_b, .i_port_wr, .i_mode_sel, .i_w_data,
    .i_cmp_result, .i_sleeping, .i_rtc_inc, .i_rtc_value, .i_rtc_irq_en, .i_rtc_flag_clr,
    .i_timer_irq, .i_ack_slot, .i_ctx, .i_ret, .i_ret_add, .i_ret_literal, .o_swap_data,
    .o_swap_valid, .o_port_b_dir, .o_port_b_wake_enable, .o_port_b_edge_select,
    .o_port_b_wake_pending, .o_rtc_pending, .o_irq_req, .o_irq_enter, .o_wakeup, .o_ctx_load,
    .o_ctx_load_valid, .o_rtc_add_valid, .o_rtc_add, .o_global_en);
  pwic_pin_model pins (.i_clk(i_ref_clk), .i_target(tgt), .i_lag(lag), .o_pins(i_port_b));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic cmp(input string nm, input logic [35:0] e, input logic [35:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask : cmp
  task automatic take(ref logic [71:0] q[$], input string nm, input logic [35:0] g);
    logic [71:0] n;
    if (q.size() == 0) begin
      errors++;
      $display("CHECK FAILED %s exp none got %h", nm, g);
    end else begin
      n = q.pop_front();
      cmp(nm, n[35:0] & n[71:36], g & n[71:36]);
    end
  endtask : take
  task automatic wr(input logic [7:0] s, input logic [7:0] v);
    i_mode_sel <= s;
    i_w_data <= v;
    i_port_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_port_wr <= 1'b0;
    @(posedge i_ref_clk);
  endtask : wr
  task automatic sw(input logic [7:0] s, input logic [7:0] e, input logic [7:0] v);
    q_swap.push_back({36'hFF, 28'h0, e});
    wr(s, v);
  endtask : sw
  task automatic pin(input logic [7:0] v, input logic [7:0] e, input logic r);
    lag <= 4'($urandom_range(3));
    tgt <= v;
    repeat (10) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    cmp("pending", 36'(e), 36'(o_port_b_wake_pending));
    cmp("request", 36'(r), 36'(o_irq_req));
    @(posedge i_ref_clk);
  endtask : pin
  // one-cycle strobe: 0 ack, 1 return, 2 add-literal return, 3 counter step, 4 flag clear
  task automatic pulse(input int k);
    {i_ack_slot, i_ret, i_ret_add, i_rtc_inc, i_rtc_flag_clr} <= 5'h10 >> k;
    @(posedge i_ref_clk);
    {i_ack_slot, i_ret, i_ret_add, i_rtc_inc, i_rtc_flag_clr} <= 5'h00;
    repeat (3) @(posedge i_ref_clk);
  endtask : pulse
  task automatic lvl(input logic g, input logic r);
    @(negedge i_ref_clk);
    cmp("global", 36'(g), 36'(o_global_en));
    cmp("request", 36'(r), 36'(o_irq_req));
    @(posedge i_ref_clk);
  endtask : lvl
  task automatic tally_and_finish();
    if (q_swap.size() + q_ctx.size() + q_add.size() + q_enter.size() != 0) errors++;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  // result watcher takes the oldest note for each output that fires, except a context load on wakeup
  always @(negedge i_ref_clk) begin
    if (o_swap_valid) take(q_swap, "swap", 36'(o_swap_data));
    if (o_ctx_load_valid && !o_wakeup) take(q_ctx, "context", o_ctx_load);
    if (o_ctx_load_valid && !o_wakeup) take(q_enter, "enter", 36'(o_irq_enter));
    if (o_rtc_add_valid) take(q_add, "counter add", 36'(o_rtc_add));
  end
  initial begin
    i_ref_clk = 1'b0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    #400000;
    errors++;
    tally_and_finish();
  end
  initial begin
    {i_resetn, i_port_wr, i_sleeping, i_rtc_inc, i_rtc_irq_en, i_rtc_flag_clr} = '0;
    {i_ack_slot, i_ret, i_ret_add, i_mode_sel, i_w_data, i_rtc_value, i_ret_literal} = '0;
    {i_timer_irq, i_ctx, tgt, lag, errors, checks} = '0;
    void'($urandom(84318));
    i_cmp_result = 8'($urandom());
    d = 8'($urandom());
    saved = 36'({$urandom(), $urandom()});
    repeat (20) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    @(negedge i_ref_clk);
    cmp("enable", 36'hFF, 36'(o_port_b_wake_enable));
    cmp("edge", 36'hFF, 36'(o_port_b_edge_select));
    cmp("pending", 36'h0, 36'(o_port_b_wake_pending));
    @(posedge i_ref_clk);
    wr(8'h1F, d);
    wr(8'h1A, 8'h0F);
    sw(8'h19, 8'h00, 8'h00);
    wr(8'h1B, 8'hFE);
    sw(8'h18, i_cmp_result, 8'h5A);
    @(negedge i_ref_clk);
    cmp("dir", 36'(d), 36'(o_port_b_dir));
    cmp("edge", 36'h0F, 36'(o_port_b_edge_select));
    cmp("enable", 36'hFE, 36'(o_port_b_wake_enable));
    @(posedge i_ref_clk);
    pin(8'hF0, 8'hF0, 1'b0);
    pin(8'h0F, 8'hF0, 1'b0);
    pin(8'h00, 8'hFF, 1'b1);
    sw(8'h19, 8'hFF, 8'h00);
    pin(8'h01, 8'h00, 1'b0);
    pin(8'h00, 8'h01, 1'b1);
    i_ctx <= saved;
    q_ctx.push_back({36'hFFF00E000, 36'h0});
    q_enter.push_back({36'h1, 36'h1});
    pulse(0);
    lvl(1'b0, 1'b0);
    sw(8'h19, 8'h01, 8'h00);
    pin(8'h01, 8'h00, 1'b0);
    pin(8'h00, 8'h01, 1'b0);
    i_ctx <= ~saved;
    q_ctx.push_back({36'hFFFFFFFFF, saved});
    q_enter.push_back({36'h1, 36'h0});
    pulse(1);
    lvl(1'b1, 1'b1);
    q_ctx.push_back({36'hFFF00E000, 36'h0});
    q_enter.push_back({36'h1, 36'h1});
    pulse(0);
    sw(8'h19, 8'h01, 8'h00);
    i_ret_literal <= d;
    q_add.push_back({36'hFF, 28'h0, d});
    q_ctx.push_back({36'hFFFFFFFFF, ~saved});
    q_enter.push_back({36'h1, 36'h0});
    pulse(2);
    lvl(1'b1, 1'b0);
    i_timer_irq <= 6'($urandom_range(63, 1));
    repeat (2) @(posedge i_ref_clk);
    lvl(1'b1, 1'b1);
    i_timer_irq <= '0;
    i_rtc_irq_en <= 1'b1;
    i_rtc_value <= 8'hFF;
    pulse(3);
    @(negedge i_ref_clk);
    cmp("rollover", 36'h1, 36'(o_rtc_pending));
    @(posedge i_ref_clk);
    pulse(4);
    @(negedge i_ref_clk);
    cmp("rollover", 36'h0, 36'(o_rtc_pending));
    @(posedge i_ref_clk);
    pin(8'h01, 8'h00, 1'b0);
    pin(8'h00, 8'h01, 1'b1);
    i_sleeping <= 1'b1;
    for (int k = 0; k < 6 && o_wakeup !== 1'b1; k++) @(negedge i_ref_clk);
    cmp("wakeup", 36'h1, 36'(o_wakeup));
    cmp("wake pc", 36'hFFF, 36'(o_ctx_load.pc));
    @(posedge i_ref_clk);
    i_sleeping <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
    tally_and_finish();
  end
endmodule : pwic_top_tb
